// *** verilog/vtflt_map.vh ***
// register map, field positions and rate constants of the v/t converter and filter control
`ifndef VTF_MAP_VH
`define VTF_MAP_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define VTF_ADDR_CUR 32'hffff050c
`define VTF_ADDR_VT 32'hffff0510
`define VTF_ADDR_FLT 32'hffff0518
`define VTF_ADDR_STAT 32'hffff0520

// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define VTF_CUR_RST 16'h0000
`define VTF_VT_RST 16'h0000
`define VTF_FLT_RST 16'h0007
`define VTF_VT_WMASK 16'he2f0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define VTF_VT_EN 15
`define VTF_VT_EXC_T 13
`define VTF_VT_EXC_G 14
`define VTF_VT_CODING 9
`define VTF_VT_IN_HI 7
`define VTF_VT_IN_LO 6
`define VTF_VT_REF_HI 5
`define VTF_VT_REF_LO 4
`define VTF_FLT_CHOP 15
`define VTF_FLT_RAVG 14
`define VTF_FLT_AF_HI 13
`define VTF_FLT_AF_LO 8
`define VTF_FLT_NOTCH 7
`define VTF_FLT_SF_HI 6
`define VTF_FLT_SF_LO 0
`define VTF_ST_SETTLED 0
`define VTF_ST_LP 1
`define VTF_ST_TEMP 2
`define VTF_ST_EN 3

// ----------------------------------------------------------------
// codes
// ----------------------------------------------------------------
`define VTF_IN_VBAT 2'h0
`define VTF_IN_EXT_T 2'h1
`define VTF_IN_INT_T 2'h2
`define VTF_IN_SHORT 2'h3
`define VTF_REF_SUPPLY 2'h3
`define VTF_SF_60HZ 7'h7e
`define VTF_SF_50HZ 7'h7f

// ----------------------------------------------------------------
// rates and counts
// ----------------------------------------------------------------
`define VTF_CLK_KHZ 17'h186a0
`define VTF_MOD_KHZ 10'h200
`define VTF_LP_KHZ 10'h083
`define VTF_MOD_HZ 20'h7d000
`define VTF_FORCED_HZ_60 20'h0003c
`define VTF_FORCED_HZ_50 20'h00032
`define VTF_DEC_SHIFT 6
`define VTF_AVG_BASE 7'h03
`define VTF_CHOP_EXTRA 21'h000003
`define VTF_SETTLE_PLAIN 3'h3
`define VTF_SETTLE_RAVG 3'h4
`define VTF_SETTLE_AVG 3'h1
`define VTF_SETTLE_AVG_RAVG 3'h2
`define VTF_SETTLE_CHOP 3'h2

`endif

// *** verilog/vtflt_tick_gen.v ***
// modulator clock tick generator, 512 kHz or 131 kHz from hclk
`timescale 1ns/10ps
`include "vtflt_map.vh"
module vtflt_tick_gen #(
    parameter CLK_KHZ = `VTF_CLK_KHZ
) (
    input wire hclk,
    input wire hresetn,
    input wire low_power,
    output reg mod_tick
);

reg [16:0] acc_r;
wire [9:0] inc;
wire [17:0] sum;
wire [17:0] lim;

assign inc = low_power ? `VTF_LP_KHZ : `VTF_MOD_KHZ;
assign sum = {1'b0, acc_r} + {8'h00, inc};
assign lim = {1'b0, CLK_KHZ[16:0]};

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        acc_r <= 17'h00000;
        mod_tick <= 1'b0;
    end else if (sum >= lim) begin
        acc_r <= sum[16:0] - lim[16:0];
        mod_tick <= 1'b1;
    end else begin
        acc_r <= sum[16:0];
        mod_tick <= 1'b0;
    end
end

endmodule // vtflt_tick_gen

// *** verilog/vtflt_period_ctr.v ***
// output period counter in modulator ticks
`timescale 1ns/10ps
module vtflt_period_ctr #(
    parameter W = 21
) (
    input wire hclk,
    input wire hresetn,
    input wire restart,
    input wire run,
    input wire tick,
    input wire [W-1:0] period,
    output reg period_done
);

reg [W-1:0] cnt_r;

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        cnt_r <= {W{1'b0}};
        period_done <= 1'b0;
    end else if (restart || !run) begin
        cnt_r <= {W{1'b0}};
        period_done <= 1'b0;
    end else if (tick) begin
        if (cnt_r + {{(W-1){1'b0}}, 1'b1} >= period) begin
            cnt_r <= {W{1'b0}};
            period_done <= 1'b1;
        end else begin
            cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
            period_done <= 1'b0;
        end
    end else begin
        period_done <= 1'b0;
    end
end

endmodule // vtflt_period_ctr

// *** verilog/vtflt_top.v ***
// v/t converter and decimation filter control with ahb-lite registers
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/10ps
`include "vtflt_map.vh"
module vtflt_top #(
    parameter PER_W = 21
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire lp_mode_pin,
    output wire vt_conv_enable,
    output wire excite_thermal_src,
    output wire excite_ground_src,
    output wire vt_unipolar,
    output wire [1:0] vt_input_sel,
    output wire hv_buffer_en,
    output wire [1:0] vt_ref_sel,
    output wire vt_ref_switched_ground_pin,
    output wire chop_en,
    output wire run_avg_en,
    output wire [5:0] averaging_factor,
    output wire second_notch_en,
    output wire [6:0] decimation_factor,
    output wire lp_clk_sel,
    output wire current_conv_reset,
    output wire vt_conv_reset,
    output wire vt_result_valid,
    output wire voltage_result_we,
    output wire temperature_result_we
);

// ----------------------------------------------------------------
// state declarations
// ----------------------------------------------------------------
localparam [19:0] PER_60HZ = `VTF_MOD_HZ / `VTF_FORCED_HZ_60;
localparam [19:0] PER_50HZ = `VTF_MOD_HZ / `VTF_FORCED_HZ_50;

reg [15:0] cur_ctrl_r;
reg [15:0] vt_ctrl_r;
reg [15:0] flt_ctrl_r;
reg [15:0] cur_ctrl_nxt;
reg [15:0] vt_ctrl_nxt;
reg [15:0] flt_ctrl_nxt;

reg dp_write_r;
reg [31:0] dp_addr_r;
reg [31:0] hrdata_r;
reg hreadyout_r;
reg hresp_r;

reg lp_meta_r;
reg lp_sync_r;

reg hv_buf_r;
reg ref_switched_ground_pin_r;
reg run_avg_r;
reg cur_reset_r;
reg vt_reset_r;
reg [2:0] settle_cnt_r;
reg settled_r;
reg result_valid_r;
reg volt_we_r;
reg temp_we_r;
reg last_temp_r;

wire addr_phase;
wire wr_cur;
wire wr_vt;
wire wr_flt;
wire cur_change;
wire vt_change;
wire flt_change;
wire conv_restart;
wire mod_tick;
wire period_done;
wire [1:0] in_sel_nxt;
wire [1:0] ref_sel_nxt;
wire chop_nxt;
wire ravg_nxt;
wire [5:0] af;
wire [6:0] sf;
wire [7:0] sf_plus1;
wire [13:0] dec_len;
wire [6:0] avg_mult;
wire [20:0] avg_len;
reg [PER_W-1:0] period_len;
reg [2:0] settle_need;
reg [31:0] rd_mux;
wire [15:0] stat_word;

// ----------------------------------------------------------------
// ahb-lite address and data phase
// ----------------------------------------------------------------
assign addr_phase = hsel && htrans[1] && hready;

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        dp_write_r <= 1'b0;
        dp_addr_r <= 32'h00000000;
        hreadyout_r <= 1'b1;
        hresp_r <= 1'b0;
    end else begin
        hreadyout_r <= 1'b1;
        hresp_r <= 1'b0;
        if (hready) begin
            dp_write_r <= addr_phase && hwrite;
            dp_addr_r <= haddr;
        end
    end
end

assign wr_cur = dp_write_r && (dp_addr_r == `VTF_ADDR_CUR);
assign wr_vt = dp_write_r && (dp_addr_r == `VTF_ADDR_VT);
assign wr_flt = dp_write_r && (dp_addr_r == `VTF_ADDR_FLT);

// ----------------------------------------------------------------
// register next values
// ----------------------------------------------------------------
always @* begin
    cur_ctrl_nxt = cur_ctrl_r;
    vt_ctrl_nxt = vt_ctrl_r;
    flt_ctrl_nxt = flt_ctrl_r;
    if (wr_cur) begin
        cur_ctrl_nxt = hwdata[15:0];
    end
    if (wr_vt) begin
        vt_ctrl_nxt = hwdata[15:0] & `VTF_VT_WMASK;
    end
    if (wr_flt) begin
        flt_ctrl_nxt = hwdata[15:0];
    end
end

assign cur_change = wr_cur && (cur_ctrl_nxt != cur_ctrl_r);
assign vt_change = wr_vt && (vt_ctrl_nxt != vt_ctrl_r);
assign flt_change = wr_flt && (flt_ctrl_nxt != flt_ctrl_r);

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        cur_ctrl_r <= `VTF_CUR_RST;
        vt_ctrl_r <= `VTF_VT_RST;
        flt_ctrl_r <= `VTF_FLT_RST;
    end else begin
        cur_ctrl_r <= cur_ctrl_nxt;
        vt_ctrl_r <= vt_ctrl_nxt;
        flt_ctrl_r <= flt_ctrl_nxt;
    end
end

// ----------------------------------------------------------------
// read data, control registers taken from next values so a write is seen at once; status from registered state
// ----------------------------------------------------------------
assign stat_word = {12'h000, vt_ctrl_r[`VTF_VT_EN], last_temp_r, lp_sync_r, settled_r};

always @* begin
    case (haddr)
        `VTF_ADDR_CUR: rd_mux = {16'h0000, cur_ctrl_nxt};
        `VTF_ADDR_VT: rd_mux = {16'h0000, vt_ctrl_nxt};
        `VTF_ADDR_FLT: rd_mux = {16'h0000, flt_ctrl_nxt};
        `VTF_ADDR_STAT: rd_mux = {16'h0000, stat_word};
        default: rd_mux = 32'h00000000;
    endcase
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hrdata_r <= 32'h00000000;
    end else if (addr_phase && !hwrite) begin
        hrdata_r <= rd_mux;
    end
end

// ----------------------------------------------------------------
// low-power mode pin synchroniser
// ----------------------------------------------------------------
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        lp_meta_r <= 1'b0;
        lp_sync_r <= 1'b0;
    end else begin
        lp_meta_r <= lp_mode_pin;
        lp_sync_r <= lp_meta_r;
    end
end

// ----------------------------------------------------------------
// converter setup decode
// ----------------------------------------------------------------
assign in_sel_nxt = vt_ctrl_nxt[`VTF_VT_IN_HI:`VTF_VT_IN_LO];
assign ref_sel_nxt = vt_ctrl_nxt[`VTF_VT_REF_HI:`VTF_VT_REF_LO];
assign chop_nxt = flt_ctrl_nxt[`VTF_FLT_CHOP];
assign ravg_nxt = flt_ctrl_nxt[`VTF_FLT_RAVG];

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hv_buf_r <= 1'b0;
        ref_switched_ground_pin_r <= 1'b0;
        run_avg_r <= 1'b0;
    end else begin
        hv_buf_r <= (in_sel_nxt == `VTF_IN_VBAT);
        ref_switched_ground_pin_r <= (ref_sel_nxt == `VTF_REF_SUPPLY) &&
            ((in_sel_nxt == `VTF_IN_EXT_T) || (in_sel_nxt == `VTF_IN_INT_T));
        run_avg_r <= ravg_nxt || chop_nxt;
    end
end

// ----------------------------------------------------------------
// converter resets
// ----------------------------------------------------------------
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        cur_reset_r <= 1'b0;
        vt_reset_r <= 1'b0;
    end else begin
        cur_reset_r <= flt_change || cur_change;
        vt_reset_r <= flt_change || cur_change || vt_change;
    end
end

// ----------------------------------------------------------------
// output period length
// ----------------------------------------------------------------
assign af = flt_ctrl_r[`VTF_FLT_AF_HI:`VTF_FLT_AF_LO];
assign sf = flt_ctrl_r[`VTF_FLT_SF_HI:`VTF_FLT_SF_LO];
assign sf_plus1 = {1'b0, sf} + 8'h01;
assign dec_len = {sf_plus1, {`VTF_DEC_SHIFT{1'b0}}};
assign avg_mult = {1'b0, af} + `VTF_AVG_BASE;
assign avg_len = {7'h00, dec_len} * {14'h0000, avg_mult};

always @* begin
    period_len = {PER_W{1'b0}};
    // forced 60 Hz and 50 Hz
    if (sf == `VTF_SF_60HZ) begin
        period_len[19:0] = PER_60HZ;
    end else if (sf == `VTF_SF_50HZ) begin
        period_len[19:0] = PER_50HZ;
    // chop adds three modulator ticks to the averaged period
    end else if (run_avg_r && flt_ctrl_r[`VTF_FLT_CHOP]) begin
        period_len = avg_len + `VTF_CHOP_EXTRA;
    end else if (af != 6'h00) begin
        period_len = avg_len;
    end else begin
        period_len = {7'h00, dec_len};
    end
end

// ----------------------------------------------------------------
// settling periods for the selected mode
// ----------------------------------------------------------------
always @* begin
    if (flt_ctrl_r[`VTF_FLT_CHOP]) begin
        settle_need = `VTF_SETTLE_CHOP;
    end else if (af != 6'h00) begin
        settle_need = run_avg_r ? `VTF_SETTLE_AVG_RAVG : `VTF_SETTLE_AVG;
    end else begin
        settle_need = run_avg_r ? `VTF_SETTLE_RAVG : `VTF_SETTLE_PLAIN;
    end
end

// ----------------------------------------------------------------
// modulator timing
// ----------------------------------------------------------------
assign conv_restart = vt_reset_r;

vtflt_tick_gen #(
    .CLK_KHZ(`VTF_CLK_KHZ)
) u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .low_power(lp_sync_r),
    .mod_tick(mod_tick)
);

vtflt_period_ctr #(
    .W(PER_W)
) u_period (
    .hclk(hclk),
    .hresetn(hresetn),
    .restart(conv_restart),
    .run(vt_ctrl_r[`VTF_VT_EN]),
    .tick(mod_tick),
    .period(period_len),
    .period_done(period_done)
);

// ----------------------------------------------------------------
// settling and result routing
// ----------------------------------------------------------------
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        settle_cnt_r <= 3'h0;
        settled_r <= 1'b0;
        result_valid_r <= 1'b0;
        volt_we_r <= 1'b0;
        temp_we_r <= 1'b0;
        last_temp_r <= 1'b0;
    end else if (conv_restart || vt_change || !vt_ctrl_r[`VTF_VT_EN]) begin
        settle_cnt_r <= 3'h0;
        settled_r <= 1'b0;
        result_valid_r <= 1'b0;
        volt_we_r <= 1'b0;
        temp_we_r <= 1'b0;
    end else if (period_done) begin
        if (!settled_r) begin
            if (settle_cnt_r + 3'h1 >= settle_need) begin
                settled_r <= 1'b1;
            end
            settle_cnt_r <= settle_cnt_r + 3'h1;
        end
        result_valid_r <= settled_r || (settle_cnt_r + 3'h1 >= settle_need);
        case (vt_ctrl_r[`VTF_VT_IN_HI:`VTF_VT_IN_LO])
            `VTF_IN_EXT_T, `VTF_IN_INT_T: begin
                volt_we_r <= 1'b0;
                temp_we_r <= settled_r || (settle_cnt_r + 3'h1 >= settle_need);
                last_temp_r <= 1'b1;
            end
            default: begin
                volt_we_r <= settled_r || (settle_cnt_r + 3'h1 >= settle_need);
                temp_we_r <= 1'b0;
                last_temp_r <= 1'b0;
            end
        endcase
    end else begin
        result_valid_r <= 1'b0;
        volt_we_r <= 1'b0;
        temp_we_r <= 1'b0;
    end
end

// ----------------------------------------------------------------
// outputs
// ----------------------------------------------------------------
assign hrdata = hrdata_r;
assign hreadyout = hreadyout_r;
assign hresp = hresp_r;
assign vt_conv_enable = vt_ctrl_r[`VTF_VT_EN];
assign excite_thermal_src = vt_ctrl_r[`VTF_VT_EXC_T];
assign excite_ground_src = vt_ctrl_r[`VTF_VT_EXC_G];
assign vt_unipolar = vt_ctrl_r[`VTF_VT_CODING];
assign vt_input_sel = vt_ctrl_r[`VTF_VT_IN_HI:`VTF_VT_IN_LO];
assign hv_buffer_en = hv_buf_r;
assign vt_ref_sel = vt_ctrl_r[`VTF_VT_REF_HI:`VTF_VT_REF_LO];
assign vt_ref_switched_ground_pin = ref_switched_ground_pin_r;
assign chop_en = flt_ctrl_r[`VTF_FLT_CHOP];
assign run_avg_en = run_avg_r;
assign averaging_factor = flt_ctrl_r[`VTF_FLT_AF_HI:`VTF_FLT_AF_LO];
assign second_notch_en = flt_ctrl_r[`VTF_FLT_NOTCH];
assign decimation_factor = flt_ctrl_r[`VTF_FLT_SF_HI:`VTF_FLT_SF_LO];
assign lp_clk_sel = lp_sync_r;
assign current_conv_reset = cur_reset_r;
assign vt_conv_reset = vt_reset_r;
assign vt_result_valid = result_valid_r;
assign voltage_result_we = volt_we_r;
assign temperature_result_we = temp_we_r;

endmodule // vtflt_top

// *** testbench/vtflt_afe_model.sv ***
// behavioural analog front end: low-power request and conversion tally
`timescale 1ns/10ps
module vtflt_afe_model (
    input wire hclk,
    input wire lp_req,
    input wire voltage_result_we,
    input wire temperature_result_we,
    output reg lp_mode_pin,
    output integer conv_count
);
    initial begin
        lp_mode_pin = 1'b0;
        conv_count = 0;
    end
    always @(lp_req) begin
        lp_mode_pin <= #3 lp_req;
    end
    always @(posedge hclk) begin
        if (voltage_result_we || temperature_result_we) begin
            conv_count <= conv_count + 1;
        end
    end
endmodule // vtflt_afe_model

// *** testbench/vtflt_top_chk.sv ***
// assertion checker for the v/t converter and filter control ports
`timescale 1ns/10ps
module vtflt_top_chk (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire lp_mode_pin,
    input wire vt_conv_enable,
    input wire excite_thermal_src,
    input wire excite_ground_src,
    input wire vt_unipolar,
    input wire [1:0] vt_input_sel,
    input wire hv_buffer_en,
    input wire [1:0] vt_ref_sel,
    input wire vt_ref_switched_ground_pin,
    input wire chop_en,
    input wire run_avg_en,
    input wire [5:0] averaging_factor,
    input wire second_notch_en,
    input wire [6:0] decimation_factor,
    input wire lp_clk_sel,
    input wire current_conv_reset,
    input wire vt_conv_reset,
    input wire vt_result_valid,
    input wire voltage_result_we,
    input wire temperature_result_we
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    reg dph_vt_r;
    reg dph_flt_r;
    reg [15:0] flt_r;
    wire take_w = hsel && htrans[1] && hready && hwrite;
    wire temp_w = (vt_input_sel == 2'h1) || (vt_input_sel == 2'h2);
    // ----------------------------------------
    // write data phase tracking
    // ----------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_vt_r <= 1'b0;
            dph_flt_r <= 1'b0;
            flt_r <= 16'h0007;
        end else begin
            dph_vt_r <= take_w && (haddr == 32'hffff0510);
            dph_flt_r <= take_w && (haddr == 32'hffff0518);
            if (dph_flt_r) begin
                flt_r <= hwdata[15:0];
            end
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
    en_follow_a: assert property (dph_vt_r |=> vt_conv_enable == $past(hwdata[15]))
        else $error("enable bit not applied");
    exc_map_a: assert property (dph_vt_r |=>
        {excite_ground_src, excite_thermal_src} == $past(hwdata[14:13]))
        else $error("excitation sources wrong");
    coding_sel_a: assert property (dph_vt_r |=> vt_unipolar == $past(hwdata[9]))
        else $error("coding bit not applied");
    hv_buffer_a: assert property ($past(hresetn) |-> hv_buffer_en == (vt_input_sel == 2'h0))
        else $error("buffer enable wrong");
    result_route_a: assert property (
        voltage_result_we == (vt_result_valid && !temp_w)
        && temperature_result_we == (vt_result_valid && temp_w))
        else $error("result routed wrongly");
    ref_ground_a: assert property ($past(hresetn) |->
        vt_ref_switched_ground_pin == ((vt_ref_sel == 2'h3) && temp_w)) else $error("reference ground wrong");
    flt_reset_a: assert property (dph_flt_r && (hwdata[15:0] != flt_r) |->
        ##[1:3] (vt_conv_reset && current_conv_reset)) else $error("filter change without reset");
    flt_fields_a: assert property (dph_flt_r |=>
        {chop_en, averaging_factor, second_notch_en, decimation_factor}
        == {$past(hwdata[15]), $past(hwdata[13:0])}) else $error("filter fields wrong");
    chop_avg_a: assert property (chop_en |-> run_avg_en)
        else $error("chop without running average");
    lp_clock_a: assert property (lp_mode_pin [*5] |=> lp_clk_sel)
        else $error("low-power clock not selected");
    settle_hold_a: assert property ($rose(vt_conv_reset) |=> !vt_result_valid [*8])
        else $error("result right after converter reset");
    valid_en_a: assert property (vt_result_valid |-> vt_conv_enable)
        else $error("result while disabled");
    temp_seen_c: cover property (temperature_result_we);
    flt_write_c: cover property (dph_flt_r);
    lp_seen_c: cover property (lp_clk_sel);
endmodule // vtflt_top_chk

// *** testbench/vtflt_top_tb.sv ***
// self-checking bench of the v/t converter and filter control
`timescale 1ns/10ps
`include "vtflt_map.vh"
`define TB_CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module vtflt_top_tb;
    reg hclk, hresetn, hsel, hwrite, lp_req, rd_dph;
    reg [31:0] haddr, hwdata;
    reg [1:0] htrans;
    reg [2:0] hsize;
    wire [31:0] hrdata;
    wire hreadyout, hresp, lp_mode_pin, vt_conv_enable, excite_thermal_src, excite_ground_src;
    wire vt_unipolar, hv_buffer_en, vt_ref_switched_ground_pin, chop_en, run_avg_en, second_notch_en;
    wire lp_clk_sel, current_conv_reset, vt_conv_reset, vt_result_valid;
    wire voltage_result_we, temperature_result_we;
    wire [1:0] vt_input_sel, vt_ref_sel;
    wire [5:0] averaging_factor;
    wire [6:0] decimation_factor;
    integer conv_count, err_count = 0, checks = 0, n_vt = 0, n_cur = 0, i, k;
    reg [31:0] r, e;
    reg [15:0] vprev = 16'h0000, fprev = 16'h0007;
    reg [31:0] rd_q[$];
    reg [1:0] res_q[$];
    vtflt_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lp_mode_pin(lp_mode_pin),
        .vt_conv_enable(vt_conv_enable), .excite_thermal_src(excite_thermal_src),
        .excite_ground_src(excite_ground_src), .vt_unipolar(vt_unipolar),
        .vt_input_sel(vt_input_sel), .hv_buffer_en(hv_buffer_en), .vt_ref_sel(vt_ref_sel),
        .vt_ref_switched_ground_pin(vt_ref_switched_ground_pin), .chop_en(chop_en), .run_avg_en(run_avg_en),
        .averaging_factor(averaging_factor), .second_notch_en(second_notch_en),
        .decimation_factor(decimation_factor), .lp_clk_sel(lp_clk_sel),
        .current_conv_reset(current_conv_reset), .vt_conv_reset(vt_conv_reset),
        .vt_result_valid(vt_result_valid), .voltage_result_we(voltage_result_we),
        .temperature_result_we(temperature_result_we));
    vtflt_afe_model u_afe (.hclk(hclk), .lp_req(lp_req), .voltage_result_we(voltage_result_we),
        .temperature_result_we(temperature_result_we), .lp_mode_pin(lp_mode_pin),
        .conv_count(conv_count));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // ----------------------------------------
    // output monitor
    // ----------------------------------------
    always @(posedge hclk) begin
        n_vt = n_vt + (vt_conv_reset === 1'b1);
        n_cur = n_cur + (current_conv_reset === 1'b1);
        if (rd_dph) begin
            e = rd_q.pop_front();
            `TB_CHK(hrdata, e)
        end
        if (vt_result_valid) begin
            `TB_CHK({voltage_result_we, temperature_result_we}, res_q.size() ? res_q.pop_front() : 2'h3)
        end
    end
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic xfer(input [31:0] a, input w, input [31:0] d, input [31:0] x);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (!hreadyout);
        htrans <= 2'h0;
        hwdata <= d;
        if (!w) begin
            rd_q.push_back(x);
            rd_dph <= 1'b1;
        end
        do @(posedge hclk); while (!hreadyout);
        rd_dph <= 1'b0;
        hsel <= 1'b0;
    endtask
    task automatic wr_rst(input [31:0] a, input [31:0] d, input integer ev, input integer ec);
        integer v0, c0;
        v0 = n_vt;
        c0 = n_cur;
        xfer(a, 1'b1, d, 32'h0);
        repeat (4) @(posedge hclk);
        @(negedge hclk);
        `TB_CHK(n_vt - v0, ev)
        `TB_CHK(n_cur - c0, ec)
    endtask
    task final_report;
        $display("comparisons %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (70000) @(posedge hclk);
        err_count++;
        final_report;
    end
    initial begin
        {hsel, hwrite, lp_req, rd_dph, haddr, hwdata, htrans, hresetn} = 0;
        hsize = 3'h2;
        void'($urandom(622));
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(`VTF_ADDR_VT, 1'b0, 32'h0, 32'h0);
        xfer(`VTF_ADDR_FLT, 1'b0, 32'h0, 32'h7);
        xfer(32'hffff0530, 1'b1, 32'h1234, 32'h0);
        xfer(32'hffff0530, 1'b0, 32'h0, 32'h0);
        for (i = 0; i < 4; i++) begin
            r = $urandom() & 32'h0000e2f0;
            wr_rst(`VTF_ADDR_VT, r, r[15:0] != vprev, 0);
            vprev = r[15:0];
            `TB_CHK({excite_ground_src, excite_thermal_src}, r[14:13])
            `TB_CHK(vt_unipolar, r[9])
            `TB_CHK(vt_ref_sel, r[5:4])
            xfer(`VTF_ADDR_VT, 1'b0, 32'h0, r);
        end
        for (i = 0; i < 4; i++) begin
            r = 32'h8030 | (i << 6);
            wr_rst(`VTF_ADDR_VT, r, r[15:0] != vprev, 0);
            vprev = r[15:0];
            `TB_CHK(hv_buffer_en, i == 0)
            `TB_CHK(vt_input_sel, i[1:0])
            `TB_CHK(vt_ref_switched_ground_pin, i == 1 || i == 2)
            `TB_CHK(vt_conv_enable, 1'b1)
        end
        for (i = 0; i < 3; i++) begin
            // decimation kept at or below 31
            r = ($urandom() & 32'h0000ff9f) ^ 32'h0000ff00 * (i == 2);
            wr_rst(`VTF_ADDR_FLT, r, r[15:0] != fprev, r[15:0] != fprev);
            fprev = r[15:0];
            `TB_CHK({chop_en, run_avg_en}, {r[15], r[15] | r[14]})
            `TB_CHK({averaging_factor, second_notch_en}, r[13:7])
            `TB_CHK(decimation_factor, r[6:0])
        end
        wr_rst(`VTF_ADDR_FLT, r, 0, 0);
        wr_rst(`VTF_ADDR_FLT, 32'h7e, 1, 1);
        `TB_CHK(decimation_factor, `VTF_SF_60HZ)
        fprev = 16'h007e;
        wr_rst(`VTF_ADDR_CUR, 32'h1, 1, 1);
        wr_rst(`VTF_ADDR_VT, 32'h0, 1, 0);
        `TB_CHK(vt_conv_enable, 1'b0)
        wr_rst(`VTF_ADDR_FLT, 32'h0, fprev != 16'h0, fprev != 16'h0);
        res_q.push_back(2'h1);
        res_q.push_back(2'h1);
        wr_rst(`VTF_ADDR_VT, 32'h8040, 1, 0);
        k = 0;
        while (!vt_result_valid && k < 40000) begin
            @(posedge hclk);
            k++;
        end
        `TB_CHK(k > 36800 && k < 38200, 1'b1)
        k = 0;
        @(posedge hclk);
        while (!vt_result_valid && k < 14000) begin
            @(posedge hclk);
            k++;
        end
        `TB_CHK(k > 12300 && k < 12700, 1'b1)
        lp_req <= 1'b1;
        repeat (8) @(posedge hclk);
        @(negedge hclk);
        `TB_CHK(lp_clk_sel, 1'b1)
        `TB_CHK(conv_count, 2)
        xfer(`VTF_ADDR_STAT, 1'b0, 32'h0, 32'hf);
        final_report;
    end
endmodule // vtflt_top_tb
bind vtflt_top vtflt_top_chk u_chk (.*);
